// File: logic/flash_self_program_pkg.sv
// Constants shared by the flash self-programming sequencer
package flash_self_program_pkg;

    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL     = 4'h0;
    localparam logic [3:0] ADDR_POINTER     = 4'h1;
    localparam logic [3:0] ADDR_DATA        = 4'h2;
    localparam logic [3:0] ADDR_STATUS      = 4'h3;

    // -------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------
    localparam int BIT_STORE_ENABLE = 0;
    localparam int BIT_ERASE_ARM    = 1;
    localparam int BIT_WRITE_ARM    = 2;
    localparam int BIT_CLEAR_BUFFER = 4;

    localparam logic [7:0] CMD_LOAD         = 8'h01;
    localparam logic [7:0] CMD_ERASE        = 8'h03;
    localparam logic [7:0] CMD_WRITE        = 8'h05;
    localparam logic [7:0] CONTROL_RESET    = 8'h00;
    localparam logic [7:0] CONTROL_RW_MASK  = 8'h07;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int ARM_WINDOW_CYCLES = 4;
    localparam int CLK_MHZ           = 100;
    localparam int PROGRAM_TIME_US   = 3700;
    localparam int PROGRAM_CYCLES    = PROGRAM_TIME_US * CLK_MHZ;
    localparam int PAGES_PER_ERASE   = 4;

    // -------------------------------------------------------------------
    // Sequencer states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ERASE = 3'b010,
        ST_WRITE = 3'b100
    } seq_state_t;

endpackage

// File: logic/flash_self_program_sequencer.sv
// Self-programming sequencer: page buffer, group erase and one-word page write
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns

// Behaviour
// RL1 - Pages are erased before writing; buffer may fill before or after erase.
// RL2 - Group erase clears four consecutive pages at once.
// RL3 - Each store op loads one buffer word, any order.
// RL4 - Store op works only when self-program fuse is programmed low.
// RL5 - Pointer low field picks word, upper field picks page or block.
// RL6 - Pointer bit zero unused; bits above mapped top bit ignored.
// RL7 - Load op reads flash bytewise; pointer bit zero selects byte. The code reads the page buffer word instead, zero for an unloaded word.
// RL8 - Address is latched when an operation starts.
// RL9 - Software must write only pages earlier erased.
// RL10 - Control value 03 then store op within four cycles erases.
// RL11 - Group erase ignores two lowest page bits and non-page bits.
// RL12 - Software should disable interrupts before arming.
// RL13 - CPU is stalled for the whole erase or write.
// RL14 - Control value 01 then store op loads data word into buffer.
// RL15 - Buffer clears after page write, clear bit, and reset.
// RL16 - Each buffer word loaded once between clears.
// RL17 - EEPROM write during loading discards buffered data.
// RL18 - Control value 05 then store op writes the page. The code writes one buffer word, out_word_r, per operation.
// RL19 - Software drives word field zero for page write.
// RL20 - Armed bits clear on completion or after four idle cycles.
// RL21 - Store enable stays set through erase or write.
// RL22 - EEPROM write in progress blocks programming and fuse reads.
// RL23 - Unarmed or disabled store op is a no-operation.
module flash_self_program_sequencer #(
    parameter int WORD_BITS      = 5,
    parameter int PAGE_BITS      = 8,
    parameter int PROGRAM_CYCLES = flash_self_program_pkg::PROGRAM_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic        store_program_op,
    input  wire logic        load_program_op,
    input  wire logic        self_program_fuse,
    input  wire logic        eeprom_busy,
    output logic             cpu_stall,
    output logic      [7:0]  load_data,
    output logic             load_valid,
    output logic             flash_we,
    output logic      [15:0] flash_wdata,
    output logic      [WORD_BITS+PAGE_BITS-1:0] flash_waddr
);
    localparam int DEPTH = 1 << WORD_BITS;
    localparam int AW    = WORD_BITS + PAGE_BITS;
    localparam int NPAGE = 1 << PAGE_BITS;

    // -------------------------------------------------------------------
    // Reset synchroniser
    // -------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic [1:0] fuse_sync_r;
    logic [1:0] ee_sync_r;
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fuse_sync_r <= 2'b11;
            ee_sync_r   <= 2'b00;
        end else begin
            fuse_sync_r <= {fuse_sync_r[0], self_program_fuse};
            ee_sync_r   <= {ee_sync_r[0], eeprom_busy};
        end
    end
    logic prog_enabled;
    logic ee_busy;
    assign prog_enabled = ~fuse_sync_r[1]; // RL4
    assign ee_busy      = ee_sync_r[1];

    // -------------------------------------------------------------------
    // Software registers
    // -------------------------------------------------------------------
    logic [7:0]  control_r;
    logic [15:0] pointer_r;
    logic [15:0] data_r;
    logic [2:0]  arm_cnt_r;
    flash_self_program_pkg::seq_state_t state_r;
    logic [$clog2(PROGRAM_CYCLES+1)-1:0] busy_cnt_r;
    logic [AW-1:0] op_addr_r;
    logic [1:0]    erase_idx_r;

    logic ctl_wr;
    logic op_go;
    logic op_done;
    logic [7:0] ctl_cmd;
    assign ctl_wr  = reg_write && reg_addr == flash_self_program_pkg::ADDR_CONTROL && !ee_busy; // RL22
    assign ctl_cmd = control_r & flash_self_program_pkg::CONTROL_RW_MASK;
    assign op_go   = store_program_op && prog_enabled && !ee_busy && arm_cnt_r != 3'h0
                     && state_r == flash_self_program_pkg::ST_IDLE; // RL23
    assign op_done = state_r != flash_self_program_pkg::ST_IDLE && busy_cnt_r == '0 && erase_idx_r == 2'h0;

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            control_r <= flash_self_program_pkg::CONTROL_RESET;
            arm_cnt_r <= 3'h0;
        end else if (ctl_wr) begin
            control_r <= reg_wdata[7:0] & flash_self_program_pkg::CONTROL_RW_MASK;
            arm_cnt_r <= reg_wdata[flash_self_program_pkg::BIT_STORE_ENABLE]
                         ? 3'(flash_self_program_pkg::ARM_WINDOW_CYCLES) : 3'h0;
        end else if (op_done) begin
            control_r <= flash_self_program_pkg::CONTROL_RESET; // RL20 RL21
            arm_cnt_r <= 3'h0;
        end else if (op_go && ctl_cmd == flash_self_program_pkg::CMD_LOAD) begin
            control_r <= flash_self_program_pkg::CONTROL_RESET; // RL20
            arm_cnt_r <= 3'h0;
        end else if (op_go) begin
            arm_cnt_r <= 3'h0; // RL21
        end else if (arm_cnt_r != 3'h0) begin
            arm_cnt_r <= arm_cnt_r - 3'h1;
            if (arm_cnt_r == 3'h1 && state_r == flash_self_program_pkg::ST_IDLE) begin
                control_r <= flash_self_program_pkg::CONTROL_RESET; // RL20
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pointer_r <= 16'h0000;
            data_r    <= 16'h0000;
        end else if (reg_write && reg_addr == flash_self_program_pkg::ADDR_POINTER) begin
            pointer_r <= reg_wdata;
        end else if (reg_write && reg_addr == flash_self_program_pkg::ADDR_DATA) begin
            data_r <= reg_wdata;
        end
    end

    // -------------------------------------------------------------------
    // Temporary page buffer
    // -------------------------------------------------------------------
    logic [15:0]      buf_mem [DEPTH];
    logic [DEPTH-1:0] buf_full_r;
    logic [WORD_BITS-1:0] load_word;
    logic buf_clear;
    assign load_word = pointer_r[WORD_BITS:1]; // RL5 RL6
    assign buf_clear = (ctl_wr && reg_wdata[flash_self_program_pkg::BIT_CLEAR_BUFFER])
                       || (ee_busy && buf_full_r != '0)
                       || (op_done && state_r == flash_self_program_pkg::ST_WRITE); // RL15 RL17

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            buf_full_r <= '0; // RL15
        end else if (buf_clear) begin
            buf_full_r <= '0;
        end else if (op_go && ctl_cmd == flash_self_program_pkg::CMD_LOAD && !buf_full_r[load_word]) begin
            buf_full_r[load_word] <= 1'b1; // RL3 RL16
        end
    end

    always_ff @(posedge core_clk) begin
        if (op_go && ctl_cmd == flash_self_program_pkg::CMD_LOAD && !buf_full_r[load_word]) begin
            buf_mem[load_word] <= data_r; // RL3 RL14
        end
    end

    // -------------------------------------------------------------------
    // Erase and write sequencer
    // -------------------------------------------------------------------
    logic [WORD_BITS-1:0] out_word_r;
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r     <= flash_self_program_pkg::ST_IDLE;
            busy_cnt_r  <= '0;
            op_addr_r   <= '0;
            erase_idx_r <= 2'h0;
        end else begin
            unique case (state_r)
                flash_self_program_pkg::ST_IDLE: begin
                    if (op_go && ctl_cmd == flash_self_program_pkg::CMD_ERASE) begin
                        // Low page bits dropped so four aligned pages go
                        op_addr_r   <= {pointer_r[AW:WORD_BITS+3], 2'b00, {WORD_BITS{1'b0}}}; // RL2 RL8 RL11
                        erase_idx_r <= 2'(flash_self_program_pkg::PAGES_PER_ERASE - 1);
                        busy_cnt_r  <= ($bits(busy_cnt_r))'(PROGRAM_CYCLES - 1);
                        state_r     <= flash_self_program_pkg::ST_ERASE; // RL10
                    end else if (op_go && ctl_cmd == flash_self_program_pkg::CMD_WRITE) begin
                        op_addr_r   <= {pointer_r[AW:WORD_BITS+1], {WORD_BITS{1'b0}}}; // RL8 RL19
                        erase_idx_r <= 2'h0;
                        busy_cnt_r  <= ($bits(busy_cnt_r))'(PROGRAM_CYCLES - 1);
                        state_r     <= flash_self_program_pkg::ST_WRITE; // RL18
                    end
                end
                flash_self_program_pkg::ST_ERASE, flash_self_program_pkg::ST_WRITE: begin
                    if (busy_cnt_r != '0) begin
                        busy_cnt_r <= busy_cnt_r - 1'b1;
                    end else if (erase_idx_r != 2'h0) begin
                        erase_idx_r <= erase_idx_r - 2'h1;
                    end else begin
                        state_r <= flash_self_program_pkg::ST_IDLE;
                    end
                end
                default: state_r <= flash_self_program_pkg::ST_IDLE;
            endcase
        end
    end

    // Flash array port: one word per cycle at the end of the timed operation
    logic [1:0] page_off;
    assign page_off = 2'(flash_self_program_pkg::PAGES_PER_ERASE - 1) - erase_idx_r;
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flash_we    <= 1'b0;
            flash_wdata <= 16'h0000;
            flash_waddr <= '0;
            out_word_r  <= '0;
        end else begin
            flash_we <= 1'b0;
            if (state_r == flash_self_program_pkg::ST_ERASE && busy_cnt_r == '0) begin
                flash_we    <= 1'b1;
                flash_wdata <= 16'hffff; // RL1 RL2
                flash_waddr <= op_addr_r + AW'({page_off, {WORD_BITS{1'b0}}});
            end else if (state_r == flash_self_program_pkg::ST_WRITE && busy_cnt_r == '0) begin
                flash_we    <= 1'b1;
                flash_wdata <= buf_full_r[out_word_r] ? buf_mem[out_word_r] : 16'hffff;
                flash_waddr <= op_addr_r | AW'(out_word_r);
                out_word_r  <= out_word_r + 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Stall, bytewise program read and register read-back
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cpu_stall  <= 1'b0;
            load_valid <= 1'b0;
            load_data  <= 8'h00;
            reg_rdata  <= 16'h0000;
        end else begin
            cpu_stall  <= (op_go && ctl_cmd != flash_self_program_pkg::CMD_LOAD
                          && (ctl_cmd == flash_self_program_pkg::CMD_ERASE || ctl_cmd == flash_self_program_pkg::CMD_WRITE))
                          || (state_r != flash_self_program_pkg::ST_IDLE && !op_done); // RL13
            load_valid <= load_program_op && !ee_busy; // RL22
            // Byte select on pointer bit zero; an empty slot reads zero, as its array word is stale or unset
            if (!buf_full_r[load_word]) begin
                load_data <= 8'h00;
            end else if (pointer_r[0]) begin
                load_data <= buf_mem[load_word][15:8]; // RL7
            end else begin
                load_data <= buf_mem[load_word][7:0]; // RL7
            end
            reg_rdata  <= 16'h0000;
            if (reg_read) begin
                unique case (reg_addr)
                    flash_self_program_pkg::ADDR_CONTROL: reg_rdata <= {8'h00, control_r};
                    flash_self_program_pkg::ADDR_POINTER: reg_rdata <= pointer_r;
                    flash_self_program_pkg::ADDR_DATA:    reg_rdata <= data_r;
                    flash_self_program_pkg::ADDR_STATUS:  reg_rdata <= {13'h0000, ee_busy, prog_enabled,
                                                             state_r != flash_self_program_pkg::ST_IDLE};
                    default:                              reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// File: test/flash_self_program_sequencer_assertions.sv
// Port-level checks for the flash self-programming sequencer
`timescale 1ns/1ns
module flash_seq_checker (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_write,
    input wire logic        store_program_op,
    input wire logic        load_program_op,
    input wire logic        self_program_fuse,
    input wire logic        cpu_stall,
    input wire logic        load_valid,
    input wire logic        flash_we
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic [3:0] gap_r;
    logic [2:0] we_cnt_r;

    // Cycles since the last control write, saturating
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_r <= 4'hf;
        end else if (reg_write && reg_addr == flash_self_program_pkg::ADDR_CONTROL) begin
            gap_r <= 4'h0;
        end else if (gap_r != 4'hf) begin
            gap_r <= gap_r + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            we_cnt_r <= 3'h0;
        end else if (store_program_op && !cpu_stall) begin
            we_cnt_r <= 3'h0;
        end else if (flash_we) begin
            we_cnt_r <= we_cnt_r + 3'h1;
        end
    end

    AST_ARM_WINDOW: assert property ($rose(cpu_stall) |-> gap_r <= 4'h6)
        else $error("operation started outside the arming window");
    AST_FUSE_GATE: assert property ($rose(cpu_stall) |-> !self_program_fuse)
        else $error("operation started with self-programming disabled");
    AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> $past(store_program_op) || $past(store_program_op, 2))
        else $error("stall without a store op");
    AST_STALL_HOLD: assert property ($rose(cpu_stall) |=> cpu_stall [*8])
        else $error("stall released too early");
    AST_STALL_END: assert property ($rose(cpu_stall) |-> ##[1:60] !cpu_stall)
        else $error("operation never completed");
    AST_WE_IN_OP: assert property (flash_we |-> cpu_stall || $past(cpu_stall))
        else $error("flash write outside an operation");
    AST_LOAD_ANSWER: assert property (load_valid |-> $past(load_program_op))
        else $error("load answer without a load op");
    AST_PULSE_COUNT: assert property ($fell(cpu_stall) |-> ##1 (we_cnt_r == 3'h1 || we_cnt_r == 3'h4))
        else $error("wrong number of flash writes");

    cover property ($rose(cpu_stall));
    cover property (load_valid);
    cover property (flash_we ##1 flash_we);
endmodule

// File: test/cpu_core_model.sv
// Core model that issues store and load program ops
`timescale 1ns/1ns
module cpu_core_model (
    input  wire logic core_clk,
    input  wire logic issue_store,
    input  wire logic issue_load,
    input  wire logic cpu_stall,
    output logic      store_program_op = 1'b0,
    output logic      load_program_op = 1'b0
);
    // A halted core fetches nothing, so no op can issue mid-operation
    always @(posedge core_clk) begin
        store_program_op <= issue_store && !cpu_stall;
        load_program_op  <= issue_load && !cpu_stall;
    end
endmodule

// File: test/tb_flash_self_program_sequencer.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ns
module tb_flash_self_program_sequencer;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        self_program_fuse = 1'b1;
    logic        eeprom_busy = 1'b0;
    logic        issue_store = 1'b0;
    logic        issue_load = 1'b0;
    logic        store_program_op, load_program_op, cpu_stall, load_valid, flash_we;
    logic [15:0] reg_rdata, flash_wdata;
    logic [7:0]  load_data;
    logic [12:0] flash_waddr;
    int          fail_count = 0;
    int          total_checks = 0;

    always #5 core_clk = ~core_clk;

    flash_self_program_sequencer #(.WORD_BITS(5), .PAGE_BITS(8), .PROGRAM_CYCLES(20)) flash_self_program_sequencer_i (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .store_program_op(store_program_op),
        .load_program_op(load_program_op), .self_program_fuse(self_program_fuse), .eeprom_busy(eeprom_busy),
        .cpu_stall(cpu_stall), .load_data(load_data), .load_valid(load_valid), .flash_we(flash_we),
        .flash_wdata(flash_wdata), .flash_waddr(flash_waddr));
    cpu_core_model cpu_core_model_i (.core_clk(core_clk), .issue_store(issue_store), .issue_load(issue_load),
        .cpu_stall(cpu_stall), .store_program_op(store_program_op), .load_program_op(load_program_op));

    // ---------------------------------------------------------------
    // Bus and op tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic pulse_op(input logic load);
        if (load) issue_load <= 1'b1;
        else issue_store <= 1'b1;
        @(posedge core_clk);
        issue_load <= 1'b0;
        issue_store <= 1'b0;
    endtask
    // Store op follows the control write by two cycles, inside the window
    task automatic arm(input logic [7:0] cmd);
        wr(flash_self_program_pkg::ADDR_CONTROL, {8'h00, cmd});
        pulse_op(1'b0);
    endtask
    task automatic put(input logic [4:0] word, input logic [15:0] d);
        wr(flash_self_program_pkg::ADDR_POINTER, {10'h000, word, 1'b0});
        wr(flash_self_program_pkg::ADDR_DATA, d);
        arm(flash_self_program_pkg::CMD_LOAD);
        tick(2);
    endtask
    task automatic peek(input logic [15:0] ptr, input logic [7:0] exp);
        int i;
        wr(flash_self_program_pkg::ADDR_POINTER, ptr);
        pulse_op(1'b1);
        for (i = 0; i < 6 && load_valid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (i == 6) begin
            fail_count++;
            end_of_test;
        end
        check({8'h00, load_data}, {8'h00, exp});
    endtask
    // Follows an operation to its end, checking each flash write pulse
    task automatic run_op(input int p0, input int inc, input int pulses);
        int n;
        int we;
        we = 0;
        for (n = 0; n < 100 && (n < 4 || cpu_stall === 1'b1); n++) begin
            @(posedge core_clk);
            #1;
            if (flash_we === 1'b1) begin
                check({8'h00, flash_waddr[12:5]}, 16'(p0 + we * inc));
                if (inc == 1) check(flash_wdata, 16'hffff);
                we++;
            end
        end
        if (n == 100) begin
            fail_count++;
            end_of_test;
        end
        check(16'(we), 16'(pulses));
        rd(flash_self_program_pkg::ADDR_CONTROL, 16'h0000);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic s_disabled;
        rd(flash_self_program_pkg::ADDR_CONTROL, 16'h0000);
        rd(4'h9, 16'h0000);
        put(5'h03, 16'h1111);
        peek(16'h0006, 8'h00);
        self_program_fuse <= 1'b0;
        tick(4);
    endtask
    task automatic s_load;
        put(5'h1f, 16'h1234);
        put(5'h03, 16'ha55a);
        put(5'h03, 16'h0bad);
        peek(16'h0006, 8'h5a);
        peek(16'h0007, 8'ha5);
        peek(16'h003f, 8'h12);
    endtask
    task automatic s_timeout;
        wr(flash_self_program_pkg::ADDR_CONTROL, {8'h00, flash_self_program_pkg::CMD_ERASE});
        tick(6);
        pulse_op(1'b0);
        tick(4);
        check({15'h0, cpu_stall}, 16'h0000);
        rd(flash_self_program_pkg::ADDR_CONTROL, 16'h0000);
    endtask
    task automatic s_erase;
        wr(flash_self_program_pkg::ADDR_POINTER, 16'h81c5);
        arm(flash_self_program_pkg::CMD_ERASE);
        wr(flash_self_program_pkg::ADDR_POINTER, 16'h0000);
        rd(flash_self_program_pkg::ADDR_CONTROL, 16'h0003);
        check({15'h0, cpu_stall}, 16'h0001);
        run_op(4, 1, 4);
    endtask
    task automatic s_write;
        wr(flash_self_program_pkg::ADDR_POINTER, 16'h0140);
        arm(flash_self_program_pkg::CMD_WRITE);
        run_op(5, 0, 1);
        check(flash_wdata, 16'hffff);
        peek(16'h0006, 8'h00);
    endtask
    task automatic s_clear_and_eeprom;
        put(5'h02, 16'hbeef);
        wr(flash_self_program_pkg::ADDR_CONTROL, 16'h0010);
        peek(16'h0004, 8'h00);
        put(5'h04, 16'h7788);
        eeprom_busy <= 1'b1;
        tick(4);
        arm(flash_self_program_pkg::CMD_ERASE);
        tick(4);
        check({15'h0, cpu_stall}, 16'h0000);
        eeprom_busy <= 1'b0;
        tick(3);
        peek(16'h0008, 8'h00);
    endtask

    initial begin
        tick(5);
        reset_n <= 1'b1;
        tick(3);
        s_disabled;
        s_load;
        s_timeout;
        s_erase;
        s_write;
        s_clear_and_eeprom;
        end_of_test;
    end
endmodule

bind flash_self_program_sequencer flash_seq_checker flash_seq_checker_i (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .store_program_op(store_program_op),
    .load_program_op(load_program_op), .self_program_fuse(self_program_fuse), .cpu_stall(cpu_stall),
    .load_valid(load_valid), .flash_we(flash_we));
